// >>> sct_ctrl.sv
// Purpose: Host-side SDRAM controller that keeps command spacing
// Assumes: One bank open at a time, single-word accesses
// Notes:   Writes close with auto-precharge, reads with explicit close
//
// Operation
// R1: Activates and refreshes spaced by row cycle
// R2: Precharge between 42 ns and 100 us
// R3: Precharge to activate at least 20 ns
// R4: Activate to column command at least 20 ns
// R5: Activates across banks at least 14 ns
// R6: Two cycles from last write data to precharge
// R7: Auto-precharge write: five cycles before activate
// R8: 4096 refreshes within every 64 ms
// R9: Command waits one clock plus 3 ns after CKE
// R10: Column commands may follow every cycle
// R11: Device suspends clock one cycle after CKE low
// R12: Device resumes clock one cycle after CKE high
// R13: Write mask acts in the same cycle
// R14: Read mask floats lanes two cycles later
// R15: First write data with the write command
// R16: Burst stop one cycle after last data
// R17: New column command one cycle after data
// R18: Two cycles after mode load before activate
// R19: Start operation 200 us after power-up
// R20: Inhibit, precharge all, two refreshes, mode load
// R21: Round waits up, issue no-ops meanwhile

`timescale 1ns/1ps
`default_nettype none

module sct_ctrl #(
  parameter int INIT_CYC    = sct_pkg::INIT_CYC_DEF,
  parameter int RAS_MAX_CYC = sct_pkg::RAS_MAX_CYC_DEF
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     req_valid,
  input  wire sct_pkg::sct_req_s        req,
  input  wire logic                     pd_req,
  output logic                          req_ack,
  output logic                          rd_valid,
  output logic [sct_pkg::DQ_W-1:0]      rd_data,
  output logic                          init_done,
  output sct_pkg::sct_pins_s            sd_pins,
  output logic [sct_pkg::DQ_W-1:0]      sd_dq_out,
  output logic                          sd_dq_oe,
  input  wire logic [sct_pkg::DQ_W-1:0] sd_dq_in
);
  import sct_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // States, Gray along the start-up path
  typedef enum logic [3:0] {
    ST_RST   = 4'h0,
    ST_INIT  = 4'h1,
    ST_IPRE  = 4'h3,
    ST_IREF  = 4'h2,
    ST_IMRS  = 4'h6,
    ST_IDLE  = 4'h7,
    ST_RW    = 4'h5,
    ST_PRE   = 4'h4,
    ST_PDOWN = 4'hF
  } sct_state_e;

  sct_state_e            state_reg, state_next;   // Sequencer
  sct_pins_s             pins_reg, pins_next;     // Memory pins
  logic [DQ_W-1:0]       dq_out_reg, dq_out_next; // Write data
  logic                  dq_oe_reg, dq_oe_next;   // Data drive
  sct_req_s              hold_reg, hold_next;     // Taken access
  logic                  ack_reg, ack_next;       // Take pulse
  logic [1:0]            iref_reg, iref_next;     // Start-up refreshes
  logic                  init_reg, init_next;     // Start-up over
  logic                  ref_due_reg, ref_due_next;
  logic [RD_PIPE_LEN-1:0] rd_pipe_reg, rd_pipe_next;
  logic                  rd_valid_reg, rd_valid_next;
  logic [DQ_W-1:0]       rd_data_reg, rd_data_next;
  logic [DQ_W-1:0]       dq_in_reg;               // Pad capture

  logic             wait_ld, rc_ld, ras_ld, ref_clr;
  logic [TMR_W-1:0] wait_val;
  logic             wait_done, rc_done, ras_done, ref_done;

  ////////////////////////////////////////////////////////////////////
  // Timers: command wait, row cycle, activate-to-close, refresh tick
  sct_timer #(.W(TMR_W)) u_wait (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .load     (wait_ld),
    .load_val (wait_val),
    .done     (wait_done)
  );

  sct_timer #(.W(TMR_W)) u_rc (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .load     (rc_ld),
    .load_val (TMR_W'(RC_CYC - 1)),
    .done     (rc_done)
  );

  sct_timer #(.W(TMR_W)) u_ras (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .load     (ras_ld),
    .load_val (TMR_W'(RAS_CYC - 1)),
    .done     (ras_done)
  );

  // Free running; reloads itself each time it expires
  sct_timer #(.W(TMR_W)) u_ref (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .load     (ref_done),
    .load_val (TMR_W'(REF_INT_CYC - 1)),
    .done     (ref_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Sequencer: every wait defaults to NOP on the command pins
  always_comb begin
    state_next    = state_reg;
    pins_next     = pins_reg;
    pins_next.cmd = CMD_NOP;   // R21
    pins_next.dqm = DQM_IDLE;
    dq_out_next   = dq_out_reg;
    dq_oe_next    = 1'b0;
    hold_next     = hold_reg;
    ack_next      = 1'b0;
    iref_next     = iref_reg;
    init_next     = init_reg;
    wait_ld       = 1'b0;
    wait_val      = '0;
    rc_ld         = 1'b0;
    ras_ld        = 1'b0;
    ref_clr       = 1'b0;
    case (state_reg)
      // Arm the power-up settle wait
      ST_RST: begin
        wait_ld    = 1'b1;
        wait_val   = TMR_W'(INIT_CYC - 1); // R19
        state_next = ST_INIT;
      end
      // Only NOPs until the settle time is over
      ST_INIT: begin
        if (wait_done) begin
          state_next = ST_IPRE; // R20
        end
      end
      // Close every bank
      ST_IPRE: begin
        pins_next.cmd            = CMD_PRE;
        pins_next.addr           = '0;
        pins_next.addr[AP_BIT]   = 1'b1;
        wait_ld                  = 1'b1;
        wait_val                 = TMR_W'(RP_CYC - 1); // R3
        state_next               = ST_IREF;
      end
      // Two refreshes, row cycle apart
      ST_IREF: begin
        if (wait_done && rc_done) begin
          pins_next.cmd = CMD_REF; // R1
          rc_ld         = 1'b1;
          wait_ld       = 1'b1;
          wait_val      = TMR_W'(RC_CYC - 1);
          iref_next     = iref_reg + 2'h1;
          if (iref_reg == 2'(INIT_REF_NUM - 1)) begin
            state_next = ST_IMRS; // R20
          end
        end
      end
      // Program the mode register, then hold off
      ST_IMRS: begin
        if (wait_done) begin
          pins_next.cmd  = CMD_LMR;
          pins_next.ba   = '0;
          pins_next.addr = MODE_WORD;
          wait_ld        = 1'b1;
          wait_val       = TMR_W'(MRD_CYC - 1); // R18
          init_next      = 1'b1;
          state_next     = ST_IDLE;
        end
      end
      // Refresh first, then power-down, then a new access
      ST_IDLE: begin
        if (wait_done && rc_done) begin // R1 R3 R5 R7 R9 R18
          if (ref_due_reg) begin
            pins_next.cmd = CMD_REF; // R8
            rc_ld         = 1'b1;
            wait_ld       = 1'b1;
            wait_val      = TMR_W'(RC_CYC - 1);
            ref_clr       = 1'b1;
          end else if (pd_req) begin
            pins_next.cke = 1'b0;
            state_next    = ST_PDOWN;
          end else if (req_valid) begin
            pins_next.cmd  = CMD_ACT;
            pins_next.ba   = req.bank;
            pins_next.addr = req.row;
            hold_next      = req;
            ack_next       = 1'b1;
            rc_ld          = 1'b1;
            ras_ld         = 1'b1;
            wait_ld        = 1'b1;
            wait_val       = TMR_W'(RCD_CYC - 1); // R4
            state_next     = ST_RW;
          end
        end
      end
      // Column command; writes close themselves
      ST_RW: begin
        if (wait_done) begin
          pins_next.addr              = '0;
          pins_next.addr[COL_W-1:0]   = hold_reg.col;
          if (hold_reg.write) begin
            // Waiting for tRAS keeps the internal close legal
            if (ras_done) begin // R2
              pins_next.cmd          = CMD_WR;
              pins_next.addr[AP_BIT] = 1'b1;
              pins_next.dqm          = hold_reg.mask;
              dq_out_next            = hold_reg.wdata; // R15
              dq_oe_next             = 1'b1;
              wait_ld                = 1'b1;
              wait_val               = TMR_W'(DAL_CYC - 1); // R6 R7
              state_next             = ST_IDLE;
            end
          end else begin
            // Low mask here unmasks data two cycles on
            pins_next.cmd = CMD_RD;
            pins_next.dqm = '0; // R14
            wait_ld       = 1'b1;
            wait_val      = TMR_W'(CCD_CYC - 1); // R10 R16 R17
            state_next    = ST_PRE;
          end
        end
      end
      // Close the read bank once tRAS is met
      ST_PRE: begin
        if (wait_done && ras_done) begin // R2
          pins_next.cmd  = CMD_PRE;
          pins_next.ba   = hold_reg.bank;
          pins_next.addr = '0;
          wait_ld        = 1'b1;
          wait_val       = TMR_W'(RP_CYC - 1); // R3
          state_next     = ST_IDLE;
        end
      end
      // CKE low; leave for a refresh or when released
      ST_PDOWN: begin
        if (ref_due_reg || !pd_req) begin
          pins_next.cke = 1'b1;
          wait_ld       = 1'b1;
          wait_val      = TMR_W'(CKE_EXIT_CYC); // R9 R12
          state_next    = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_RST;
      end
    endcase
  end

  // Sequencer registers; CKE and DQM high at power-up
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_RST;
      pins_reg   <= '{cke: 1'b1, cmd: CMD_NOP, ba: '0, addr: '0,
                      dqm: DQM_IDLE};
      dq_out_reg <= '0;
      dq_oe_reg  <= 1'b0;
      hold_reg   <= '0;
      ack_reg    <= 1'b0;
      iref_reg   <= '0;
      init_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pins_reg   <= pins_next;
      dq_out_reg <= dq_out_next;
      dq_oe_reg  <= dq_oe_next;
      hold_reg   <= hold_next;
      ack_reg    <= ack_next;
      iref_reg   <= iref_next;
      init_reg   <= init_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Refresh due flag; a new tick beats a same-cycle clear
  always_comb begin
    ref_due_next = ref_done | (ref_due_reg & ~ref_clr); // R8
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_due_reg <= 1'b0;
    end else begin
      ref_due_reg <= ref_due_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read return: data lands CAS latency after the command on the pins
  always_comb begin
    rd_pipe_next  = {rd_pipe_reg[RD_PIPE_LEN-2:0],
                     (pins_reg.cmd == CMD_RD)};
    rd_valid_next = rd_pipe_reg[RD_PIPE_LEN-1];
    rd_data_next  = rd_pipe_reg[RD_PIPE_LEN-1] ? dq_in_reg : rd_data_reg;
  end

  // Memory is on ref_clk, so one pad flop is enough here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pipe_reg  <= '0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
      dq_in_reg    <= '0;
    end else begin
      rd_pipe_reg  <= rd_pipe_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
      dq_in_reg    <= sd_dq_in;
    end
  end

  assign req_ack   = ack_reg;
  assign rd_valid  = rd_valid_reg;
  assign rd_data   = rd_data_reg;
  assign init_done = init_reg;
  assign sd_pins   = pins_reg;
  assign sd_dq_out = dq_out_reg;
  assign sd_dq_oe  = dq_oe_reg;

  ////////////////////////////////////////////////////////////////////
  // Checking aid: cycles since each event on the pins, saturating
  localparam int EV_ACT = 0;
  localparam int EV_PRE = 1;
  localparam int EV_REF = 2;
  localparam int EV_LMR = 3;
  localparam int EV_WR  = 4;
  localparam int EV_CKE = 5;   // Counts from the last CKE-low cycle
  localparam int EV_N   = 6;

  logic [EV_N-1:0]    ev;
  logic [SINCE_W-1:0] since_reg  [EV_N];
  logic [SINCE_W-1:0] since_next [EV_N];

  always_comb begin
    ev[EV_ACT] = (pins_reg.cmd == CMD_ACT);
    ev[EV_PRE] = (pins_reg.cmd == CMD_PRE);
    ev[EV_REF] = (pins_reg.cmd == CMD_REF);
    ev[EV_LMR] = (pins_reg.cmd == CMD_LMR);
    ev[EV_WR]  = (pins_reg.cmd == CMD_WR);
    ev[EV_CKE] = ~pins_reg.cke;
    for (int i = 0; i < EV_N; i++) begin
      if (ev[i]) begin
        since_next[i] = SINCE_W'(1);
      end else if (since_reg[i] != SINCE_RST) begin
        since_next[i] = since_reg[i] + SINCE_W'(1);
      end else begin
        since_next[i] = since_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < EV_N; i++) begin
        since_reg[i] <= SINCE_RST;
      end
    end else begin
      for (int i = 0; i < EV_N; i++) begin
        since_reg[i] <= since_next[i];
      end
    end
  end

  act_rc_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!reset_n)
    ev[EV_ACT] |-> (since_reg[EV_ACT] >= RC_CYC) &&
                   (since_reg[EV_REF] >= RC_CYC))
    else $error("activate closer than row cycle");

  ref_rc_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!reset_n)
    ev[EV_REF] |-> (since_reg[EV_REF] >= RC_CYC) &&
                   (since_reg[EV_ACT] >= RC_CYC))
    else $error("refresh closer than row cycle");

  pre_ras_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!reset_n)
    (ev[EV_PRE] && init_reg) |-> (since_reg[EV_ACT] >= RAS_CYC))
    else $error("precharge before activate-to-close time");

  ras_max_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!reset_n)
    // Next count: in the ACT cycle the register still holds the old gap
    (state_reg == ST_RW || state_reg == ST_PRE) |->
      (since_next[EV_ACT] < RAS_MAX_CYC))
    else $error("row held open too long");

  act_rp_a: assert property ( // R3
    @(posedge ref_clk) disable iff (!reset_n)
    (ev[EV_ACT] || ev[EV_REF]) |-> (since_reg[EV_PRE] >= RP_CYC))
    else $error("activate too soon after precharge");

  rw_rcd_a: assert property ( // R4
    @(posedge ref_clk) disable iff (!reset_n)
    (pins_reg.cmd == CMD_RD || ev[EV_WR]) |->
      (since_reg[EV_ACT] >= RCD_CYC) && (since_reg[EV_ACT] >= RRD_CYC))
    else $error("column command too soon after activate");

  dal_wait_a: assert property ( // R7
    @(posedge ref_clk) disable iff (!reset_n)
    ev[EV_WR] |-> ##1 (!ev[EV_ACT] && !ev[EV_REF] && !ev[EV_PRE])[*4])
    else $error("command inside write auto-precharge window");

  mrd_wait_a: assert property ( // R18
    @(posedge ref_clk) disable iff (!reset_n)
    (ev[EV_ACT] || ev[EV_REF]) |-> (since_reg[EV_LMR] >= MRD_CYC))
    else $error("command too soon after mode load");

  cke_exit_a: assert property ( // R9
    @(posedge ref_clk) disable iff (!reset_n)
    (pins_reg.cmd != CMD_NOP) |->
      (pins_reg.cke && since_reg[EV_CKE] > CKE_EXIT_CYC))
    else $error("command too soon after clock enable");

  ref_budget_a: assert property ( // R8
    @(posedge ref_clk) disable iff (!reset_n)
    init_reg |-> (since_reg[EV_REF] <= REF_INT_CYC + REF_SLACK_CYC))
    else $error("refresh interval overrun");

  wr_data_a: assert property ( // R15
    @(posedge ref_clk) disable iff (!reset_n)
    ev[EV_WR] |-> (sd_dq_oe && sd_dq_out == hold_reg.wdata) ##1 !sd_dq_oe)
    else $error("write data not with write command");

endmodule : sct_ctrl

`default_nettype wire

// >>> sct_ctrl_bench.sv
// Purpose: Self-checking bench for the SDRAM command-timing controller
// Assumes: Short start-up count, inputs change on the falling edge
// Notes:   A monitor measures the gaps before each ACT, REF, RD, WR and PRE command on the memory pins
`timescale 1ns/1ps
`default_nettype none
module sct_ctrl_bench;
  import sct_pkg::*;
  logic            ref_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            req_valid = 1'b0;
  logic            pd_req = 1'b0;
  sct_req_s        req = '0;
  logic            req_ack, rd_valid, init_done, sd_dq_oe;
  logic [DQ_W-1:0] rd_data, sd_dq_out, sd_dq_in;
  sct_pins_s       sd_pins;
  int n_fail = 0, checks_done = 0, cyc = 0, n_cmd = 0, n_ref = 0;
  int last_act = -999, last_pre = -999, last_ref = -999;
  int last_lmr = -999, last_wr = -999, last_low = -999;
  logic [15:0] seq = 16'h0000; // First four commands after reset
  always #5 ref_clk = ~ref_clk;
  sct_ctrl #(.INIT_CYC(50), .RAS_MAX_CYC(10000)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .pd_req(pd_req), .req_ack(req_ack),
    .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done), .sd_pins(sd_pins),
    .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in));
  sct_mem_model mem (.ref_clk(ref_clk), .pins(sd_pins), .dq_wr(sd_dq_out),
    .dq_oe(sd_dq_oe), .dq_rd(sd_dq_in));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ok(input string what, input logic c);
    chk(what, 32'h1, {31'h0, c});
  endtask : ok
  task automatic final_report;
    $display("Counts: checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////
  // Monitor: gaps between commands, plus the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (!sd_pins.cke) last_low = cyc;
    if (reset_n && sd_pins.cmd != CMD_NOP) begin
      ok("wake_gap", cyc - last_low >= CKE_EXIT_CYC + 1);
      if (n_cmd < 4) seq = {seq[11:0], sd_pins.cmd};
      if (n_cmd == 0) ok("pre_all", sd_pins.addr[AP_BIT]);
      n_cmd++;
      case (sd_pins.cmd)
        CMD_ACT: begin
          ok("act_gap", cyc - last_act >= RC_CYC && cyc - last_ref >= RC_CYC);
          ok("pre_act", cyc - last_pre >= RP_CYC);
          ok("mode_act", cyc - last_lmr >= MRD_CYC);
          ok("wr_act", cyc - last_wr >= DAL_CYC);
          last_act = cyc;
        end
        CMD_REF: begin
          ok("ref_gap", cyc - last_ref >= RC_CYC && cyc - last_act >= RC_CYC);
          if (init_done) ok("ref_rate", cyc - last_ref <= REF_INT_CYC + REF_SLACK_CYC);
          ok("mode_ref", cyc - last_lmr >= MRD_CYC && cyc - last_wr >= DAL_CYC);
          last_ref = cyc;
          n_ref++;
        end
        CMD_RD, CMD_WR: begin
          ok("act_col", cyc - last_act >= RCD_CYC);
          if (sd_pins.cmd == CMD_WR) last_wr = cyc;
        end
        CMD_PRE: begin
          ok("act_pre", cyc - last_act >= RAS_CYC);
          ok("wr_pre", cyc - last_wr >= DPL_CYC);
          last_pre = cyc;
        end
        default: begin
          chk("mode_word", {20'h0, MODE_WORD}, {20'h0, sd_pins.addr});
          last_lmr = cyc;
        end
      endcase
    end
    // Hang limit, last so nothing follows the report
    if (cyc > 6000) begin
      n_fail++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // One access; returns once the controller takes it
  task automatic access(input logic wr, input logic [1:0] b, input logic [15:0] d,
                        input logic [1:0] m);
    int n;
    @(negedge ref_clk);
    req = '{write: wr, bank: b, row: 12'h005, col: 8'h03, wdata: d, mask: m};
    req_valid = 1'b1;
    n = 0;
    while (req_ack !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b0;
    ok("ack_seen", n < 3000);
  endtask : access
  task automatic read_chk(input logic [1:0] b, input logic [15:0] exp);
    int n;
    access(1'b0, b, 16'h0000, 2'h0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("read_word", {16'h0, exp}, {16'h0, rd_data});
  endtask : read_chk
  ////////////////////////////////////////////////////////////////////
  // Masked overwrite in every bank, then back-to-back reads
  task automatic t_rw;
    for (int b = 0; b < 4; b++) access(1'b1, b[1:0], 16'hA500 + b[15:0], 2'h0);
    for (int b = 0; b < 4; b++) access(1'b1, b[1:0], 16'h5AFF, 2'h1);
    for (int b = 0; b < 4; b++) read_chk(b[1:0], 16'h5A00 + b[15:0]);
    $display("Test t_rw done");
  endtask : t_rw
  // Power-down entry, then a write straight after wake-up
  task automatic t_pd;
    @(negedge ref_clk);
    pd_req = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("cke_low", 32'h0, {31'h0, sd_pins.cke});
    repeat (20) @(negedge ref_clk);
    pd_req = 1'b0;
    access(1'b1, 2'h2, 16'h1234, 2'h0);
    read_chk(2'h2, 16'h1234);
    $display("Test t_pd done");
  endtask : t_pd
  // Idle long enough for at least two periodic refreshes
  task automatic t_refresh;
    int n0;
    n0 = n_ref;
    repeat (3300) @(negedge ref_clk);
    ok("ref_count", n_ref - n0 >= 2);
    $display("Test t_refresh done");
  endtask : t_refresh
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge ref_clk);
    ok("reset_pins", sd_pins.cke && sd_pins.cmd == CMD_NOP && !init_done);
    reset_n = 1'b1;
    while (init_done !== 1'b1 && cyc < 500) @(negedge ref_clk);
    // Mode load is seen on the pins one edge after init_done rises
    @(negedge ref_clk);
    chk("init_order", 32'h2110, {16'h0, seq});
    $display("Test t_init done");
    t_rw();
    t_pd();
    t_refresh();
    final_report();
  end
endmodule : sct_ctrl_bench
`default_nettype wire

// >>> sct_mem_model.sv
// Purpose: Behavioural SDRAM device facing the controller in the bench
// Assumes: Burst 1, CAS latency 2, single clock
// Notes:   Undriven data shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module sct_mem_model (
  input  wire logic               ref_clk,
  input  wire sct_pkg::sct_pins_s pins,
  input  wire logic [15:0]        dq_wr,
  input  wire logic               dq_oe,
  output logic [15:0]             dq_rd
);
  import sct_pkg::*;
  logic [DQ_W-1:0]  mem [0:1023]; // Word per bank and column
  logic [9:0]       rd_idx;       // Location of the pending read
  logic [DQ_W-1:0]  rd_lanes;     // Lanes to float on the read
  logic             rd_pend;      // Read taken one edge ago
  logic             clk_on;       // Internal clock, lags cke by one
  initial begin
    dq_rd = 16'h0000;
    rd_pend = 1'b0;
    clk_on = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // Commands act only while the internal clock runs
  always @(posedge ref_clk) begin
    clk_on <= pins.cke;
    rd_pend <= clk_on && pins.cmd == CMD_RD;
    if (clk_on && pins.cmd == CMD_WR && dq_oe) begin
      for (int i = 0; i < DQM_W; i++) begin
        // Masked lane keeps its old byte
        if (!pins.dqm[i]) mem[{pins.ba, pins.addr[7:0]}][8*i +: 8] <= dq_wr[8*i +: 8];
      end
    end
    if (clk_on && pins.cmd == CMD_RD) begin
      rd_idx <= {pins.ba, pins.addr[7:0]};
      rd_lanes <= {{8{pins.dqm[1]}}, {8{pins.dqm[0]}}};
    end
    // Data stands in the cycle ending at read plus CAS latency
    if (rd_pend) dq_rd <= (mem[rd_idx] & ~rd_lanes) | (~dq_rd & rd_lanes);
    else dq_rd <= ~dq_rd;
  end
endmodule : sct_mem_model
`default_nettype wire

// >>> sct_pkg.sv
// Purpose: Constants and types for the SDRAM command-timing controller
// Assumes: 100 MHz ref_clk, slower speed grade, CAS latency 2, burst 1
// Notes:   Waits given in ns, us or ms are derived here; DPL, DAL, MRD and CCD are set in cycles

package sct_pkg;

  ////////////////////////////////////////////////////////////////////
  // Clock and printed times
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_RC_NS        = 63;     // Row cycle
  localparam int T_RAS_NS       = 42;     // Activate to precharge, least
  localparam int T_RAS_MAX_NS   = 100000; // Activate to precharge, most
  localparam int T_RP_NS        = 20;     // Precharge to activate
  localparam int T_RCD_NS       = 20;     // Activate to column command
  localparam int T_RRD_NS       = 14;     // Activate to other bank
  localparam int T_CKE_EXTRA_NS = 3;      // Extra beyond one clock
  localparam int T_REF_MS       = 64;     // Whole refresh period
  localparam int REF_ROWS       = 4096;   // Refreshes per period
  localparam int T_POWERON_US   = 200;    // Settle before operation
  localparam int T_INIT_US      = 100;    // Inhibit window

  ////////////////////////////////////////////////////////////////////
  // Cycle counts: least times round up, longest round down
  localparam int RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RRD_CYC = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKE_EXIT_CYC = 1 + (T_CKE_EXTRA_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int RAS_MAX_CYC_DEF = T_RAS_MAX_NS / CLK_PERIOD_NS;
  localparam int INIT_US = (T_POWERON_US > T_INIT_US) ? T_POWERON_US
                                                       : T_INIT_US;
  localparam int INIT_CYC_DEF = (INIT_US * 1000) / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = (T_REF_MS * 1000000 / REF_ROWS)
                               / CLK_PERIOD_NS;
  localparam int DPL_CYC = 2;   // Last data to precharge
  localparam int DAL_CYC = 5;   // Data to activate, auto-precharge
  localparam int MRD_CYC = 2;   // Mode load to activate/refresh
  localparam int CCD_CYC = 1;   // Column to column
  localparam int REF_SLACK_CYC = 32; // Worst delay of a due refresh
  localparam int INIT_REF_NUM = 2;   // Refreshes during start-up
  localparam int CAS_LAT = 2;
  localparam int RD_PIPE_LEN = CAS_LAT + 1;

  ////////////////////////////////////////////////////////////////////
  // Widths and field positions
  localparam int TMR_W  = 16;
  localparam int DQ_W   = 16;
  localparam int DQM_W  = 2;
  localparam int BA_W   = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W  = 8;
  localparam int AP_BIT = 10;   // Auto/all-bank precharge address bit
  localparam int SINCE_W = 16;

  // Burst 1, sequential, CAS latency 2, normal mode
  localparam logic [ADDR_W-1:0] MODE_WORD = 12'h020;
  localparam logic [DQM_W-1:0]  DQM_IDLE  = 2'h3;
  localparam logic [SINCE_W-1:0] SINCE_RST = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  typedef logic [3:0] sct_cmd_t;
  localparam sct_cmd_t CMD_NOP = 4'h7;
  localparam sct_cmd_t CMD_ACT = 4'h3;
  localparam sct_cmd_t CMD_RD  = 4'h5;
  localparam sct_cmd_t CMD_WR  = 4'h4;
  localparam sct_cmd_t CMD_PRE = 4'h2;
  localparam sct_cmd_t CMD_REF = 4'h1;
  localparam sct_cmd_t CMD_LMR = 4'h0;

  // Pins toward the memory
  typedef struct packed {
    logic              cke;
    sct_cmd_t          cmd;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [DQM_W-1:0]  dqm;
  } sct_pins_s;

  // One user access, single word
  typedef struct packed {
    logic              write;
    logic [BA_W-1:0]   bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [DQ_W-1:0]   wdata;
    logic [DQM_W-1:0]  mask;
  } sct_req_s;

endpackage : sct_pkg

// >>> sct_timer.sv
// Purpose: Loadable down-counter that marks an elapsed wait
// Assumes: Load wins over counting
// Notes:   Loading N-1 lets the next command go N cycles after the load

`timescale 1ns/1ps
`default_nettype none

module sct_timer #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count_reg;   // Remaining cycles
  logic [W-1:0] count_next;

  // Next count: load, else count down and rest at zero
  always_comb begin
    if (load) begin
      count_next = load_val;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end else begin
      count_next = count_reg;
    end
  end

  // Register only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);

endmodule : sct_timer

`default_nettype wire
